/* File: rtl/wdk_defines.svh */
`ifndef WDK_DEFINES_SVH
`define WDK_DEFINES_SVH

// register indices; byte address is four times the index
`define WDK_IDX_MASTER 8'hF0
`define WDK_IDX_KEY 8'hF1
`define WDK_IDX_STATUS 8'hF2

// master control field positions
`define WDK_MC_EN_BIT 7
`define WDK_MC_PER_HI 6
`define WDK_MC_PER_LO 5
`define WDK_MC_EXT_BIT 4
`define WDK_MC_FIXED 4'h3

// status field positions
`define WDK_ST_RUN_BIT 0
`define WDK_ST_FIRE_BIT 1
`define WDK_ST_SEEN_BIT 2

// power-on values
`define WDK_RST_EN 1'h1
`define WDK_RST_PER 2'h3
`define WDK_RST_EXT 1'h1

// key codes
`define WDK_KEY_STOP 8'hB1
`define WDK_KEY_CLEAR 8'h4E

// timeout periods as powers of two of the clock cycle time
`define WDK_SHIFT_0 16
`define WDK_SHIFT_1 18
`define WDK_SHIFT_2 20
`define WDK_SHIFT_3 22

// reset pulse width and clock cycle time
`define WDK_PULSE_NS 1600
`define WDK_CLK_NS 100
`define WDK_PULSE_CYC ((`WDK_PULSE_NS + `WDK_CLK_NS - 1) / `WDK_CLK_NS)

`endif

/* File: rtl/wdk_pkg.sv */
package wdk_pkg;

	typedef enum logic [1:0] {
		WDK_STOPPED = 2'b00,
		WDK_COUNTING = 2'b01,
		WDK_FIRING = 2'b10
	} wdk_mode_t;

	typedef struct packed {
		logic en;
		logic [1:0] per;
		logic ext;
	} wdk_ctrl_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} wdk_apb_rsp_t;

	typedef struct packed {
		wdk_mode_t mode;
		wdk_ctrl_t ctrl;
		logic [31:0] count;
		logic [7:0] pulse;
		logic seen;
		logic cpu_reset_n;
		logic pin_oe_n;
		logic pin_out;
		wdk_apb_rsp_t rsp;
	} wdk_state_t;

endpackage

/* File: rtl/wdk_watchdog.sv */
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
`include "wdk_defines.svh"

module wdk_watchdog
	import wdk_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int SHIFT_0 = `WDK_SHIFT_0,
	parameter int SHIFT_1 = `WDK_SHIFT_1,
	parameter int SHIFT_2 = `WDK_SHIFT_2,
	parameter int SHIFT_3 = `WDK_SHIFT_3,
	parameter int PULSE_CYC = `WDK_PULSE_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic cpu_reset_n,
	output logic reset_pin_out,
	output logic reset_pin_oe_n
);

	localparam logic [ADDR_W-1:0] ADDR_MASTER = ADDR_W'({`WDK_IDX_MASTER, 2'b00});
	localparam logic [ADDR_W-1:0] ADDR_KEY = ADDR_W'({`WDK_IDX_KEY, 2'b00});
	localparam logic [ADDR_W-1:0] ADDR_STATUS = ADDR_W'({`WDK_IDX_STATUS, 2'b00});
	localparam logic [7:0] PULSE_LAST = 8'(PULSE_CYC - 1);

	initial begin
		if (ADDR_W < 10 || ADDR_W > 32)
			$error("address width must hold the register window");
		if (SHIFT_0 < 1 || SHIFT_0 > SHIFT_1 || SHIFT_1 > SHIFT_2 || SHIFT_2 > SHIFT_3
			|| SHIFT_3 > 31)
			$error("period shifts must rise and stay within the counter");
		if (PULSE_CYC < 1 || PULSE_CYC > 256)
			$error("reset pulse must be 1 to 256 cycles");
	end

	// last count value before a timeout, for a given period code
	function automatic logic [31:0] period_last(input logic [1:0] sel);
		logic [31:0] one;
		one = 32'h0000_0001;
		case (sel)
			2'b00: period_last = (one << SHIFT_0) - one;
			2'b01: period_last = (one << SHIFT_1) - one;
			2'b10: period_last = (one << SHIFT_2) - one;
			default: period_last = (one << SHIFT_3) - one;
		endcase
	endfunction

	function automatic logic [31:0] master_image(input wdk_ctrl_t c);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[`WDK_MC_EN_BIT] = c.en;
		v[`WDK_MC_PER_HI:`WDK_MC_PER_LO] = c.per;
		v[`WDK_MC_EXT_BIT] = c.ext;
		v[3:0] = `WDK_MC_FIXED;
		master_image = v;
	endfunction

	wdk_state_t s_q;
	wdk_state_t s_d;

	logic setup;
	logic access;
	logic wr_master;
	logic wr_key;
	logic wr_status;
	logic key_stop;
	logic key_clear;
	logic mapped;
	logic timeout;

	always_comb begin
		setup = psel && !penable && !s_q.rsp.pready;
		access = psel && penable && s_q.rsp.pready;
		wr_master = access && pwrite && paddr == ADDR_MASTER;
		wr_key = access && pwrite && paddr == ADDR_KEY;
		wr_status = access && pwrite && paddr == ADDR_STATUS;
		key_stop = wr_key && pwdata[7:0] == `WDK_KEY_STOP;
		key_clear = wr_key && pwdata[7:0] == `WDK_KEY_CLEAR;
		mapped = paddr == ADDR_MASTER || paddr == ADDR_KEY || paddr == ADDR_STATUS;
		// at or past the end, so shortening the period mid-interval still fires
		timeout = s_q.mode == WDK_COUNTING && s_q.count >= period_last(s_q.ctrl.per);

		s_d = s_q;

		// bus answer: one wait-free access phase after each setup
		s_d.rsp.pready = setup;
		s_d.rsp.pslverr = setup && !mapped;
		s_d.rsp.prdata = 32'h0000_0000;
		if (setup && !pwrite) begin
			case (paddr)
				ADDR_MASTER: s_d.rsp.prdata = master_image(s_q.ctrl);
				ADDR_STATUS: begin
					s_d.rsp.prdata[`WDK_ST_RUN_BIT] = s_q.mode != WDK_STOPPED;
					s_d.rsp.prdata[`WDK_ST_FIRE_BIT] = s_q.mode == WDK_FIRING;
					s_d.rsp.prdata[`WDK_ST_SEEN_BIT] = s_q.seen;
				end
				// command register holds nothing to read back
				default: s_d.rsp.prdata = 32'h0000_0000;
			endcase
		end

		if (wr_master) begin
			s_d.ctrl.en = pwdata[`WDK_MC_EN_BIT];
			s_d.ctrl.per = pwdata[`WDK_MC_PER_HI:`WDK_MC_PER_LO];
			s_d.ctrl.ext = pwdata[`WDK_MC_EXT_BIT];
		end

		// write one clears; a timeout in the same cycle keeps it set
		if (wr_status && pwdata[`WDK_ST_SEEN_BIT])
			s_d.seen = 1'b0;

		case (s_q.mode)
			WDK_STOPPED: begin
				s_d.count = 32'h0000_0000;
				if (wr_master && pwdata[`WDK_MC_EN_BIT])
					s_d.mode = WDK_COUNTING;
			end
			WDK_COUNTING: begin
				s_d.count = s_q.count + 32'h0000_0001;
				if (key_stop && !s_q.ctrl.en) begin
					// stop only once enable was already cleared
					s_d.mode = WDK_STOPPED;
					s_d.count = 32'h0000_0000;
				end else if (key_clear) begin
					s_d.count = 32'h0000_0000;
				end else if (timeout) begin
					s_d.mode = WDK_FIRING;
					s_d.count = 32'h0000_0000;
					s_d.pulse = PULSE_LAST;
					s_d.seen = 1'b1;
					s_d.cpu_reset_n = 1'b0;
					s_d.pin_oe_n = !s_q.ctrl.ext;
				end
			end
			WDK_FIRING: begin
				// keys are not acted on while the reset pulse is out
				s_d.count = 32'h0000_0000;
				if (s_q.pulse == 8'h00) begin
					s_d.mode = WDK_COUNTING;
					s_d.cpu_reset_n = 1'b1;
					s_d.pin_oe_n = 1'b1;
				end else begin
					s_d.pulse = s_q.pulse - 8'h01;
				end
			end
			default: begin
				s_d.mode = WDK_COUNTING;
				s_d.count = 32'h0000_0000;
			end
		endcase

		// release the pulse that reset itself put on both outputs
		if (s_q.mode != WDK_FIRING) begin
			if (!timeout || s_q.mode != WDK_COUNTING) begin
				s_d.cpu_reset_n = 1'b1;
				s_d.pin_oe_n = 1'b1;
			end
		end
		s_d.pin_out = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q.mode <= WDK_COUNTING;
			s_q.ctrl.en <= `WDK_RST_EN;
			s_q.ctrl.per <= `WDK_RST_PER;
			s_q.ctrl.ext <= `WDK_RST_EXT;
			s_q.count <= 32'h0000_0000;
			s_q.pulse <= 8'h00;
			s_q.seen <= 1'b0;
			// reset reaches the processor and the pin while held
			s_q.cpu_reset_n <= 1'b0;
			s_q.pin_oe_n <= 1'b0;
			s_q.pin_out <= 1'b0;
			s_q.rsp <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.rsp.prdata;
	assign pready = s_q.rsp.pready;
	assign pslverr = s_q.rsp.pslverr;
	assign cpu_reset_n = s_q.cpu_reset_n;
	assign reset_pin_out = s_q.pin_out;
	assign reset_pin_oe_n = s_q.pin_oe_n;

endmodule // wdk_watchdog

/* File: tb/wdk_watchdog_sva.sv */
`timescale 1ns/1ns
module wdk_watchdog_sva #(
	parameter int ADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cpu_reset_n,
	input wire logic reset_pin_out,
	input wire logic reset_pin_oe_n
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rdy; psel && !penable |=> pready && psel && penable; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready after setup");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("ready held too long");
	property p_fix; pready && !pwrite && paddr == 12'h3C0 |-> prdata[3:0] == 4'h3 && !pslverr; endproperty
	a_fix: assert property (p_fix) else $error("fixed bits wrong");
	property p_key; pready && !pwrite && paddr == 12'h3C4 |-> prdata == 32'h0 && !pslverr; endproperty
	a_key: assert property (p_key) else $error("key register readable");
	property p_err; pready && pslverr |-> prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("data on error");
	property p_pin; !reset_pin_oe_n |-> !cpu_reset_n && !reset_pin_out; endproperty
	a_pin: assert property (p_pin) else $error("pin low without reset");
	// pulse stands one cycle per count step; four matches the bench's pulse setting
	property p_pulse; $fell(cpu_reset_n) |-> !cpu_reset_n [*4] ##1 cpu_reset_n; endproperty
	a_pulse: assert property (p_pulse) else $error("pulse width wrong");
	property p_rel; $rose(cpu_reset_n) |-> reset_pin_oe_n; endproperty
	a_rel: assert property (p_rel) else $error("pin held after reset");
endmodule // wdk_watchdog_sva
bind wdk_watchdog wdk_watchdog_sva #(.ADDR_W(ADDR_W)) u_sva (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .cpu_reset_n(cpu_reset_n),
	.reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n));

/* File: tb/wdk_watchdog_tb_top.sv */
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin bad_count++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module wdk_watchdog_tb_top;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, cpu_reset_n, reset_pin_out, reset_pin_oe_n, er, pin;
	int bad_count = 0;
	int n_compared = 0;
	int cyc = 0;
	int n;
	// short periods 2^4..2^7 keep the run brief
	wdk_watchdog #(.SHIFT_0(4), .SHIFT_1(5), .SHIFT_2(6), .SHIFT_3(7), .PULSE_CYC(4)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cpu_reset_n(cpu_reset_n), .reset_pin_out(reset_pin_out),
		.reset_pin_oe_n(reset_pin_oe_n));
	initial forever #50 pclk = ~pclk;
	task report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			report_and_stop();
		end
	end
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k = 0;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		if (k >= 50) bad_count++;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1, a, {24'h0, d});
	endtask
	task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] ex, input logic ee);
		apb(0, a, 32'h0);
		`CHK(nm, ex, rd)
		`CHK(nm, ee, er)
	endtask
	// stops early when the internal reset drops; pin notes any external drive
	task automatic watch(input int lim);
		n = 0;
		pin = 0;
		while (n < lim && cpu_reset_n) begin
			@(negedge pclk);
			n++;
			pin = pin | !reset_pin_oe_n;
		end
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		`CHK("rst pins", 3'b000, {cpu_reset_n, reset_pin_oe_n, reset_pin_out})
		repeat (10) @(posedge pclk);
		presetn <= 1;
		rdchk("master rst", 12'h3C0, 32'hF3, 0);
		rdchk("key rd", 12'h3C4, 32'h0, 0);
		rdchk("unmapped", 12'h3D0, 32'h0, 1);
		wr(12'h3C4, 8'h4E);
		wr(12'h3C0, 8'h0C);
		wr(12'h3C4, 8'hB1);
		rdchk("master wr", 12'h3C0, 32'h03, 0);
		rdchk("stopped", 12'h3C8, 32'h0, 0);
		watch(300);
		`CHK("no timeout", 300, n)
		wr(12'h3C0, 8'h83);
		wr(12'h3C4, 8'hB1);
		repeat (6) begin
			wr(12'h3C4, 8'h4E);
			wr(12'h3C4, 8'h55);
		end
		rdchk("kept alive", 12'h3C8, 32'h1, 0);
		for (int c = 0; c < 4; c++) begin
			wr(12'h3C0, {1'b1, c[1:0], c[0], 4'h3});
			wr(12'h3C4, 8'h4E);
			watch(400);
			`CHK("period", 1, (n >= (1 << (4 + c)) - 1 && n <= (1 << (4 + c)) + 2))
			`CHK("pin", c[0], pin)
			repeat (8) @(negedge pclk);
			`CHK("released", 1'b1, cpu_reset_n)
		end
		rdchk("seen", 12'h3C8, 32'h5, 0);
		report_and_stop();
	end
endmodule // wdk_watchdog_tb_top
